// ### verilog/cgtim_pkg.sv
// constants, types and layout of the complementary output timing block
//
// Behaviour
// - rise dead-band delays primary output turn-on
// - fall dead-band delays complementary output turn-on
// - rise blanking ignores falling events for count
// - fall blanking ignores rising events for count
// - phase count delays every accepted rising event
// - phase upper nibble reads zero, ignores writes
// - count fields kept through reset, power-up unknown
// - per-source bit picks edge or level sensing
package cgtim_pkg;

	////////////////////////////////////////////////////////////////////
	// bus widths
	localparam int DW = 8; // register data width
	localparam int AW = 3; // register address width
	localparam int NIB_W = 4; // width of one count field

	////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [AW-1:0] A_CTRL = 3'h0; // generator_control_main
	localparam logic [AW-1:0] A_SRC = 3'h1; // generator_source_select
	localparam logic [AW-1:0] A_ASD = 3'h2; // shutdown_control
	localparam logic [AW-1:0] A_DB = 3'h3; // dead_band_counts
	localparam logic [AW-1:0] A_BLK = 3'h4; // blanking_counts
	localparam logic [AW-1:0] A_PH = 3'h5; // phase_delay_count

	////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_EN_BIT = 7; // generator enable
	localparam int SRC_FALL_MODE_BIT = 7; // fall_source_edge_mode
	localparam int SRC_RISE_MODE_BIT = 6; // rise_source_edge_mode
	localparam int HI_LSB = 4; // upper nibble base
	localparam int LO_LSB = 0; // lower nibble base

	////////////////////////////////////////////////////////////////////
	// reset values of the control registers
	localparam logic [DW-1:0] CTRL_RST = 8'h00;
	localparam logic [DW-1:0] SRC_RST = 8'h00;
	localparam logic [DW-1:0] ASD_RST = 8'h00;
	localparam logic [DW-1:0] RD_NONE = 8'h00; // unmapped read value

	////////////////////////////////////////////////////////////////////
	// register bus request
	typedef struct packed {
		logic wr; // write strobe
		logic rd; // read strobe
		logic [AW-1:0] addr; // register offset
		logic [DW-1:0] wdata; // write data
	} cgtim_bus_type;

	// software count fields
	typedef struct packed {
		logic [NIB_W-1:0] rise_deadband_count;
		logic [NIB_W-1:0] fall_deadband_count;
		logic [NIB_W-1:0] rise_blank_count;
		logic [NIB_W-1:0] fall_blank_count;
		logic [NIB_W-1:0] rise_phase_count;
	} cgtim_counts_type;

	// last accepted event, one-hot
	typedef enum logic [2:0] {
		ST_OFF = 3'h1,
		ST_RISE = 3'h2,
		ST_FALL = 3'h4
	} cgtim_state_type;

endpackage

// ### verilog/cgtim_timer.sv
// one down-counting delay timer used for phase, dead-band and blanking
module cgtim_timer #(
	parameter int W = 4
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_start,
	input wire logic i_abort,
	input wire logic [W-1:0] i_count,
	output logic o_fire,
	output logic o_busy
);
	import cgtim_pkg::*;

	// refuse a width the counter cannot hold
	if (W < 1 || W > DW) begin : g_bad_width
		$error("cgtim_timer: W out of range");
	end

	logic [W-1:0] cnt_q; // remaining periods

	////////////////////////////////////////////////////////////////////
	// load on start, count down to zero, abort wins over all
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst || i_abort) begin
			cnt_q <= '0;
		end else if (i_start) begin
			cnt_q <= i_count;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////
	// fire at the last period, or at once for a zero count
	always_comb begin
		if (i_abort) begin
			o_fire = 1'b0;
		end else if (i_start) begin
			o_fire = (i_count == '0);
		end else begin
			o_fire = (cnt_q == W'(1));
		end
	end

	// busy for exactly the loaded number of periods
	assign o_busy = (cnt_q != '0);

	////////////////////////////////////////////////////////////////////
	// checks
	chk_zero_passes: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_start && !i_abort && i_count == '0 |-> o_fire && !o_busy ##1 !o_busy)
		else $error("zero count did not pass at once");

	chk_timer_busy: assert property (
		@(posedge i_core_clk) disable iff (!i_nrst)
		i_start && !i_abort && i_count != '0 |=> o_busy || i_abort)
		else $error("timer did not start counting");

endmodule

// ### verilog/cgtim_core.sv
// complementary output timing: registers, event sensing, delay counters
module cgtim_core (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire cgtim_pkg::cgtim_bus_type i_bus,
	input wire logic i_rise_src,
	input wire logic i_fall_src,
	output logic [cgtim_pkg::DW-1:0] o_rdata,
	output logic o_primary,
	output logic o_compl
);
	import cgtim_pkg::*;

	////////////////////////////////////////////////////////////////////
	// helpers

	// upper nibble of a byte
	function automatic logic [NIB_W-1:0] nib_hi(input logic [DW-1:0] b);
		nib_hi = b[HI_LSB +: NIB_W];
	endfunction

	// lower nibble of a byte
	function automatic logic [NIB_W-1:0] nib_lo(input logic [DW-1:0] b);
		nib_lo = b[LO_LSB +: NIB_W];
	endfunction

	// two nibbles packed into a byte
	function automatic logic [DW-1:0] nib_join(
		input logic [NIB_W-1:0] hi,
		input logic [NIB_W-1:0] lo
	);
		nib_join = {hi, lo};
	endfunction

	////////////////////////////////////////////////////////////////////
	// declarations
	logic [DW-1:0] ctrl_q; // generator_control_main
	logic [DW-1:0] src_q; // generator_source_select
	logic [DW-1:0] asd_q; // shutdown_control, stored only
	cgtim_counts_type cnt_q; // count fields, no reset
	logic [DW-1:0] rd_d; // read mux
	logic [DW-1:0] rdata_q; // registered read data
	logic wr_ctrl; // write decodes
	logic wr_src;
	logic wr_asd;
	logic wr_db;
	logic wr_blk;
	logic wr_ph;
	logic en; // generator enabled
	logic rise_mode; // 1 edge, 0 level
	logic fall_mode; // 1 edge, 0 level
	logic rise_prev_q; // source history for edges
	logic fall_prev_q;
	logic rise_raw; // sensed source events
	logic fall_raw;
	logic rise_evt; // accepted events
	logic fall_evt;
	logic rise_go; // rising event after phase delay
	logic prim_on; // primary turn-on instant
	logic compl_on; // complementary turn-on instant
	logic ph_busy; // phase delay running
	logic blank_f_busy; // falling events inhibited
	logic blank_r_busy; // rising events inhibited
	logic prim_q; // output flops
	logic compl_q;
	cgtim_state_type state_q; // last accepted event

	////////////////////////////////////////////////////////////////////
	// address decode

	// write strobes per register
	always_comb begin
		wr_ctrl = i_bus.wr && (i_bus.addr == A_CTRL);
		wr_src = i_bus.wr && (i_bus.addr == A_SRC);
		wr_asd = i_bus.wr && (i_bus.addr == A_ASD);
		wr_db = i_bus.wr && (i_bus.addr == A_DB);
		wr_blk = i_bus.wr && (i_bus.addr == A_BLK);
		wr_ph = i_bus.wr && (i_bus.addr == A_PH);
	end

	////////////////////////////////////////////////////////////////////
	// control registers, cleared by reset

	// enable and unused control bits
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			ctrl_q <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= i_bus.wdata;
		end
	end

	// source sensing modes
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			src_q <= SRC_RST;
		end else if (wr_src) begin
			src_q <= i_bus.wdata;
		end
	end

	// shutdown settings, held for software only
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			asd_q <= ASD_RST;
		end else if (wr_asd) begin
			asd_q <= i_bus.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// count fields: no reset term, so any reset leaves them intact
	always_ff @(posedge i_core_clk) begin
		if (wr_db) begin
			cnt_q.rise_deadband_count <= nib_hi(i_bus.wdata);
			cnt_q.fall_deadband_count <= nib_lo(i_bus.wdata);
		end
		if (wr_blk) begin
			cnt_q.rise_blank_count <= nib_hi(i_bus.wdata);
			cnt_q.fall_blank_count <= nib_lo(i_bus.wdata);
		end
		if (wr_ph) begin
			// upper nibble is dropped, not stored
			cnt_q.rise_phase_count <= nib_lo(i_bus.wdata);
		end
	end

	////////////////////////////////////////////////////////////////////
	// read path
	always_comb begin
		case (i_bus.addr)
			A_CTRL: rd_d = ctrl_q;
			A_SRC: rd_d = src_q;
			A_ASD: rd_d = asd_q;
			A_DB: rd_d = nib_join(cnt_q.rise_deadband_count,
				cnt_q.fall_deadband_count);
			A_BLK: rd_d = nib_join(cnt_q.rise_blank_count,
				cnt_q.fall_blank_count);
			A_PH: rd_d = nib_join('0, cnt_q.rise_phase_count);
			default: rd_d = RD_NONE;
		endcase
	end

	// data stand one cycle after the read strobe, else zero
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			rdata_q <= RD_NONE;
		end else if (i_bus.rd) begin
			rdata_q <= rd_d;
		end else begin
			rdata_q <= RD_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode decode
	always_comb begin
		en = ctrl_q[CTRL_EN_BIT];
		rise_mode = src_q[SRC_RISE_MODE_BIT];
		fall_mode = src_q[SRC_FALL_MODE_BIT];
	end

	// source history for edge sensing
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			rise_prev_q <= 1'b0;
			fall_prev_q <= 1'b0;
		end else begin
			rise_prev_q <= i_rise_src;
			fall_prev_q <= i_fall_src;
		end
	end

	////////////////////////////////////////////////////////////////////
	// event sensing: edge mode wants a low-to-high change,
	// level mode takes a high input unless that event already stands
	always_comb begin
		if (rise_mode) begin
			rise_raw = i_rise_src && !rise_prev_q;
		end else begin
			rise_raw = i_rise_src && (state_q != ST_RISE);
		end
		if (fall_mode) begin
			fall_raw = i_fall_src && !fall_prev_q;
		end else begin
			fall_raw = i_fall_src && (state_q != ST_FALL);
		end
	end

	// blanking gates the opposite source; fall wins a tie for safety
	always_comb begin
		fall_evt = en && fall_raw && !blank_f_busy;
		rise_evt = en && rise_raw && !blank_r_busy && !fall_evt;
	end

	////////////////////////////////////////////////////////////////////
	// last accepted event
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			state_q <= ST_OFF;
		end else begin
			case (state_q)
				ST_OFF, ST_RISE, ST_FALL: begin
					if (!en) begin
						state_q <= ST_OFF;
					end else if (fall_evt) begin
						state_q <= ST_FALL;
					end else if (rise_evt) begin
						state_q <= ST_RISE;
					end
				end
				default: state_q <= ST_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// delay timers

	// phase delay of the rising event
	cgtim_timer #(.W(NIB_W)) u_phase (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_start(rise_evt),
		.i_abort(fall_evt || !en),
		.i_count(cnt_q.rise_phase_count),
		.o_fire(rise_go),
		.o_busy(ph_busy)
	);

	// rising dead-band before primary turns on
	cgtim_timer #(.W(NIB_W)) u_rise_db (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_start(rise_go),
		.i_abort(fall_evt || !en),
		.i_count(cnt_q.rise_deadband_count),
		.o_fire(prim_on),
		.o_busy()
	);

	// falling dead-band before complementary turns on
	cgtim_timer #(.W(NIB_W)) u_fall_db (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_start(fall_evt),
		.i_abort(rise_go || !en),
		.i_count(cnt_q.fall_deadband_count),
		.o_fire(compl_on),
		.o_busy()
	);

	// after a rising event, falling input is blanked
	cgtim_timer #(.W(NIB_W)) u_blank_f (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_start(rise_evt),
		.i_abort(!en),
		.i_count(cnt_q.rise_blank_count),
		.o_fire(),
		.o_busy(blank_f_busy)
	);

	// after a falling event, rising input is blanked
	cgtim_timer #(.W(NIB_W)) u_blank_r (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_start(fall_evt),
		.i_abort(!en),
		.i_count(cnt_q.fall_blank_count),
		.o_fire(),
		.o_busy(blank_r_busy)
	);

	////////////////////////////////////////////////////////////////////
	// primary output: off at once on fall, on after rise dead-band
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst || !en) begin
			prim_q <= 1'b0;
		end else if (fall_evt) begin
			prim_q <= 1'b0;
		end else if (prim_on) begin
			prim_q <= 1'b1;
		end
	end

	// complementary output: off after rise phase delay, on after fall dead-band
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst || !en) begin
			compl_q <= 1'b0;
		end else if (rise_go) begin
			compl_q <= 1'b0;
		end else if (compl_on) begin
			compl_q <= 1'b1;
		end
	end

	// outputs straight from flops
	assign o_primary = prim_q;
	assign o_compl = compl_q;
	assign o_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_nrst);

	// rise accepted with no phase and no dead-band
	sequence s_rise_direct;
		rise_evt && cnt_q.rise_phase_count == '0
			&& cnt_q.rise_deadband_count == '0;
	endsequence

	// rise accepted with a phase delay pending
	sequence s_rise_phased;
		rise_evt && cnt_q.rise_phase_count != '0;
	endsequence

	chk_rise_no_delay: assert property (
		s_rise_direct |=> prim_q && !compl_q)
		else $error("zero counts did not drive primary next cycle");

	chk_phase_holds: assert property (
		s_rise_phased |-> !rise_go ##1 ph_busy)
		else $error("phase delay did not hold the rising event");

	chk_fall_prim_off: assert property (
		fall_evt |=> !prim_q
			&& compl_q == $past(compl_q || cnt_q.fall_deadband_count == '0))
		else $error("primary not dropped after falling event");

	chk_fall_no_db: assert property (
		fall_evt && cnt_q.fall_deadband_count == '0 |=> compl_q)
		else $error("complementary late with zero dead-band");

	chk_fall_db_wait: assert property (
		fall_evt && cnt_q.fall_deadband_count == NIB_W'(2)
			&& !compl_q ##1 !rise_go |=> !compl_q)
		else $error("complementary rose before dead-band ended");

	chk_blank_fall: assert property (
		rise_evt && cnt_q.rise_blank_count != '0 && en
			|=> !fall_evt)
		else $error("falling event passed during blanking");

	chk_blank_rise: assert property (
		blank_r_busy |-> !rise_evt)
		else $error("rising event passed during blanking");

	chk_edge_mode: assert property (
		rise_mode && i_rise_src && $past(i_rise_src) |-> !rise_evt)
		else $error("edge mode retriggered on a held level");

	chk_phase_upper: assert property (
		i_bus.rd && i_bus.addr == A_PH |=> o_rdata[DW-1:HI_LSB] == '0)
		else $error("phase upper nibble read nonzero");

	chk_db_write: assert property (
		wr_db ##1 !wr_db[*2] |=> cnt_q.fall_deadband_count
			== nib_lo($past(i_bus.wdata, 3))
			&& cnt_q.rise_deadband_count == nib_hi($past(i_bus.wdata, 3)))
		else $error("dead-band count not kept after write");

endmodule

// ### dv/cgtim_switch_stage.sv
// model of the external power stage fed by the two gate outputs
module cgtim_switch_stage (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_primary, // high side gate, high = on
	input wire logic i_compl, // low side gate, high = on
	output logic [7:0] o_overlap_cnt // cycles with both gates on
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] overlap_q; // shoot-through tally
	logic [7:0] overlap_d; // next tally
	////////////////////////////////////////
	// both switches on at once would short the supply
	always_comb begin
		overlap_d = overlap_q;
		if (i_primary && i_compl) begin
			overlap_d = overlap_q + 8'h01;
		end
	end
	// tally register, cleared by reset
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			overlap_q <= 8'h00;
		end else begin
			overlap_q <= overlap_d;
		end
	end
	assign o_overlap_cnt = overlap_q;
endmodule

// ### dv/test_complementary_output_timing.sv
// self-checking bench for the complementary output timing block
module test_complementary_output_timing;
	timeunit 1ns;
	timeprecision 1ns;
	import cgtim_pkg::*;
	logic core_clk; // 10 MHz core clock
	logic nrst; // active low reset
	cgtim_bus_type bus; // register bus request
	logic rise_src; // rising event source
	logic fall_src; // falling event source
	logic [DW-1:0] rdata; // read data
	logic primary; // primary gate
	logic compl; // complementary gate
	logic [7:0] overlap_cnt; // shoot-through count
	int n_mismatch = 0;
	int compares = 0;
	////////////////////////////////////////
	cgtim_core dut (
		.i_core_clk(core_clk),
		.i_nrst(nrst),
		.i_bus(bus),
		.i_rise_src(rise_src),
		.i_fall_src(fall_src),
		.o_rdata(rdata),
		.o_primary(primary),
		.o_compl(compl)
	);
	cgtim_switch_stage stage (
		.i_core_clk(core_clk),
		.i_nrst(nrst),
		.i_primary(primary),
		.i_compl(compl),
		.o_overlap_cnt(overlap_cnt)
	);
	// 100 ns period clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	////////////////////////////////////////
	// compare and tally
	task automatic check(input logic [7:0] got, input logic [7:0] want);
		compares++;
		if (got !== want) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	// one-cycle register write
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge core_clk);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= d;
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask
	// one-cycle read, data judged in the following cycle
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] want);
		@(posedge core_clk);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1;
		check(rdata, want);
	endtask
	// one-cycle event pulse after d idle cycles; returns at its sample edge
	task automatic ev(input logic r, input logic f, input int d);
		repeat (d) @(posedge core_clk);
		@(posedge core_clk);
		rise_src <= r;
		fall_src <= f;
		@(posedge core_clk);
		rise_src <= 1'b0;
		fall_src <= 1'b0;
	endtask
	// cycles until each gate first shows its level; 99 means never
	task automatic watch(input logic vp, input logic vc,
			input int ep, input int ec);
		int np;
		int nc;
		np = 99;
		nc = 99;
		for (int n = 0; n < 40; n++) begin
			#1;
			if (np == 99 && primary === vp) np = n;
			if (nc == 99 && compl === vc) nc = n;
			@(posedge core_clk);
		end
		check(8'(np), 8'(ep));
		check(8'(nc), 8'(ec));
	endtask
	////////////////////////////////////////
	// count fields: read back, nibble masking, kept through reset
	task automatic t_regs();
		wr(A_DB, 8'hA5);
		wr(A_BLK, 8'h3C);
		wr(A_PH, 8'hFF);
		rd(A_DB, 8'hA5);
		rd(A_BLK, 8'h3C);
		rd(A_PH, 8'h0F);
		rd(3'h6, RD_NONE);
		@(posedge core_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		rd(A_DB, 8'hA5);
		rd(A_PH, 8'h0F);
		rd(A_CTRL, CTRL_RST);
		$display("test regs done");
	endtask
	// phase and dead-band delays for one set of counts
	task automatic t_timing(input logic [3:0] p, input logic [3:0] r,
			input logic [3:0] f);
		wr(A_DB, {r, f});
		wr(A_BLK, 8'h00);
		wr(A_PH, {4'h0, p});
		ev(1'b0, 1'b1, 0);
		repeat (20) @(posedge core_clk);
		ev(1'b1, 1'b0, 0);
		watch(1'b1, 1'b0, p + r, p);
		ev(1'b0, 1'b1, 0);
		watch(1'b0, 1'b1, 0, f);
		$display("test timing %0d %0d %0d done", p, r, f);
	endtask
	// blanking windows: last blanked cycle and first open cycle
	task automatic t_blank();
		wr(A_DB, 8'h00);
		wr(A_PH, 8'h00);
		wr(A_BLK, 8'h43);
		ev(1'b1, 1'b0, 0);
		ev(1'b0, 1'b1, 2);
		watch(1'b0, 1'b1, 99, 99);
		ev(1'b0, 1'b1, 0);
		ev(1'b1, 1'b0, 1);
		watch(1'b1, 1'b0, 99, 99);
		ev(1'b1, 1'b0, 0);
		ev(1'b0, 1'b1, 3);
		#1;
		check({6'h00, primary, compl}, 8'h01);
		ev(1'b1, 1'b0, 2);
		watch(1'b1, 1'b0, 0, 0);
		$display("test blank done");
	endtask
	// falling source held high across the blanking window
	task automatic t_mode(input logic [DW-1:0] src, input int e);
		wr(A_SRC, src);
		ev(1'b0, 1'b1, 0);
		ev(1'b1, 1'b0, 4);
		@(posedge core_clk);
		fall_src <= 1'b1;
		watch(1'b0, 1'b1, e, e);
		fall_src <= 1'b0;
		$display("test mode %h done", src);
	endtask
	////////////////////////////////////////
	// verdict and end of run
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		nrst = 1'b0;
		bus = '0;
		rise_src = 1'b0;
		fall_src = 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		t_regs();
		wr(A_CTRL, 8'h80);
		wr(A_SRC, 8'hC0);
		t_timing(4'h3, 4'h5, 4'h2);
		t_timing(4'h0, 4'h0, 4'h0);
		t_timing(4'hF, 4'hF, 4'hF);
		t_blank();
		t_mode(8'h00, 4);
		t_mode(8'hC0, 99);
		check(overlap_cnt, 8'h00);
		wrap_up();
	end
	// hang guard, far beyond the expected run length
	initial begin
		#2_000_000;
		n_mismatch++;
		wrap_up();
	end
endmodule
